// >>> sslg_divider.sv
/*
 Divider producing a one-cycle enable pulse every PERIOD clocks.
 Assumes a single system clock; run gates counting.
*/
`timescale 1ns/1ns
`default_nettype none
module sslg_divider
    import sslg_pkg::*;
#(
    parameter int unsigned PERIOD = SSLG_WD_TICK_CYC
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic run,
    output logic tick
);
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } sslg_div_st_t;
    sslg_div_st_t st_r;
    sslg_div_st_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (run) begin
            if (st_r.cnt >= 32'(PERIOD - 1)) begin
                st_nxt.cnt = 32'h0;
                st_nxt.tick = 1'b1;
            end else begin
                st_nxt.cnt = st_r.cnt + 32'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;
endmodule
`default_nettype wire

// >>> sslg_host.sv
/*
 Host processor model on the supervisor bus.
 Drives at falling edges; rvld marks a read result for checking.
*/
`timescale 1ns/1ns
`default_nettype none
module sslg_host
    import sslg_pkg::*;
(
    input wire logic clk_sys,
    output sslg_bus_t bus,
    output logic rvld
);
    initial begin
        bus = '0;
        rvld = 1'b0;
    end
    task automatic xfer(input logic w, input logic [14:0] a, input logic [7:0] v, input logic chk);
        repeat ($urandom % 3) @(negedge clk_sys);
        @(negedge clk_sys);
        bus <= '{cs: 1'b1, rd_done: 1'b1, wr: w, addr: a, wdata: v};
        @(negedge clk_sys);
        bus <= '0;
        rvld <= chk;
        @(negedge clk_sys);
        rvld <= 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> sslg_pkg.sv
/*
 Package for the system supervisor logic: register addresses, bit positions,
 reset values and timing counts. Assumes a 20 MHz system clock.
*/
package sslg_pkg;
    localparam int unsigned SSLG_CLK_HZ = 20000000;
    localparam logic [14:0] SSLG_ADDR_FLAGS = 15'h7FF0;
    localparam logic [14:0] SSLG_ADDR_WDOG = 15'h7FF7;
    localparam int SSLG_FLAG_WDF_BIT = 7;
    localparam int SSLG_FLAG_AF_BIT = 6;
    localparam int SSLG_FLAG_PF_BIT = 5;
    localparam int SSLG_WD_STROBE_BIT = 7;
    localparam int SSLG_WD_WEN_N_BIT = 6;
    localparam int SSLG_MATCH_BIT = 7;
    localparam logic [5:0] SSLG_WD_TIMEOUT_RST = 6'h00;
    // Watchdog tick 32 Hz, period 31250 us
    localparam int unsigned SSLG_WD_TICK_US = 31250;
    localparam int unsigned SSLG_WD_TICK_CYC = SSLG_WD_TICK_US * (SSLG_CLK_HZ / 1000000);
    // Interrupt pulse 200 ms
    localparam int unsigned SSLG_PULSE_MS = 200;
    localparam int unsigned SSLG_PULSE_CYC = SSLG_PULSE_MS * (SSLG_CLK_HZ / 1000);

    typedef struct packed {
        logic [7:0] seconds;
        logic [7:0] minutes;
        logic [7:0] hours;
        logic [7:0] date;
    } sslg_time_t;

    typedef struct packed {
        logic cs;
        logic rd_done;
        logic wr;
        logic [14:0] addr;
        logic [7:0] wdata;
    } sslg_bus_t;
endpackage

// >>> sslg_props.sv
/*
 Port checker for the supervisor.
 Bound from the bench; one clock domain, async reset.
*/
`timescale 1ns/1ns
`default_nettype none
module sslg_props
    import sslg_pkg::*;
#(
    parameter int unsigned PULSE_CYC = SSLG_PULSE_CYC
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire sslg_bus_t bus,
    input wire sslg_time_t alarm_regs,
    input wire logic second_tick,
    input wire logic oscillator_enable_n,
    input wire logic alarm_irq_enable,
    input wire logic irq_active_high,
    input wire logic irq_pulse_mode,
    input wire logic below_lockout_threshold,
    input wire logic below_backup_supply,
    input wire logic access_enable,
    input wire logic backup_supply_sel,
    input wire logic [5:0] timeout_value,
    input wire logic [5:0] wd_count,
    input wire logic int_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic wd_wr;
    logic [31:0] pulse_r;
    assign wd_wr = bus.cs && bus.wr && bus.addr == SSLG_ADDR_WDOG && access_enable;
    // Length of the current low-going pin pulse
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pulse_r <= '0;
        end else begin
            pulse_r <= (int_oe && irq_pulse_mode && !irq_active_high) ? pulse_r + 32'h1 : '0;
        end
    end
    property p_lock; below_lockout_threshold [*4] |-> !access_enable; endproperty
    a_lock: assert property (p_lock) else $error("access open in lockout");
    property p_backup; below_backup_supply [*4] |-> backup_supply_sel; endproperty
    a_backup: assert property (p_backup) else $error("no backup select");
    property p_tmo; $changed(timeout_value) |-> $past(wd_wr); endproperty
    a_tmo: assert property (p_tmo) else $error("timeout changed without write");
    property p_reload; wd_wr && bus.wdata[SSLG_WD_STROBE_BIT] |=> wd_count == timeout_value; endproperty
    a_reload: assert property (p_reload) else $error("strobe did not reload");
    property p_step; $changed(wd_count) |-> wd_count == $past(wd_count) - 6'h01 || wd_count == timeout_value;
    endproperty
    a_step: assert property (p_step) else $error("count jumped");
    property p_osc; oscillator_enable_n [*3] |-> $stable(wd_count) || wd_count == timeout_value; endproperty
    a_osc: assert property (p_osc) else $error("count ran with oscillator off");
    property p_pulse; pulse_r <= PULSE_CYC + 1; endproperty
    a_pulse: assert property (p_pulse) else $error("pulse too long");
    property p_alarm; $rose(second_tick) && &{alarm_regs.seconds[7], alarm_regs.minutes[7], alarm_regs.hours[7],
        alarm_regs.date[7]} && alarm_irq_enable && !irq_active_high && !irq_pulse_mode && access_enable
        |-> ##[1:4] int_oe; endproperty
    a_alarm: assert property (p_alarm) else $error("no alarm interrupt");
endmodule
`default_nettype wire

// >>> sslg_supervisor.sv
/*
 Supervisor logic: alarm comparator, watchdog, power monitor flags and
 interrupt pin driver. Assumes the host bus front end delivers decoded
 strobes on clk_sys and that a one-second strobe comes from the clock core.
*/
// Operation
// - Alarm match sets alarm flag D6
// - Field compared only when match bit 0
// - Match bit is alarm register MSB
// - All match bits one: alarm every second
// - Rate follows selected fields
// - Other combinations use same per-field rule
// - Flags read clears all flags
// - Watchdog counts down on 32 Hz tick
// - Watchdog counts only with oscillator enabled
// - Power-up loads timeout and starts counting
// - Strobe D7 reloads and restarts counter
// - Zero count raises flag and interrupt
// - Expiry flag D7 sticky until read
// - Timeout writes only while D6 clear
// - Timeout zero disables watchdog
// - Below trip threshold sets power flag D5
// - Below lockout blocks access, ignores inputs
// - Backup select below backup voltage
// - Power flag stays until flags read
// - Only complete read cycles clear flags
// - Pin needs flag and enable together
// - Pulse 200 ms or level until read
`timescale 1ns/1ns
`default_nettype none
module sslg_supervisor
    import sslg_pkg::*;
#(
    parameter int unsigned WD_TICK_CYC = SSLG_WD_TICK_CYC,
    parameter int unsigned PULSE_CYC = SSLG_PULSE_CYC,
    parameter logic [5:0] TIMEOUT_INIT = SSLG_WD_TIMEOUT_RST
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire sslg_bus_t bus,
    output logic [7:0] rdata,
    input wire sslg_time_t now_time,
    input wire sslg_time_t alarm_regs,
    input wire logic second_tick,
    input wire logic oscillator_enable_n,
    input wire logic alarm_irq_enable,
    input wire logic wdog_irq_enable,
    input wire logic pfail_irq_enable,
    input wire logic irq_active_high,
    input wire logic irq_pulse_mode,
    input wire logic below_trip_threshold,
    input wire logic below_lockout_threshold,
    input wire logic below_backup_supply,
    output logic access_enable,
    output logic backup_supply_sel,
    output logic [5:0] timeout_value,
    output logic [5:0] wd_count,
    output logic int_out,
    output logic int_oe
);
    typedef struct packed {
        logic watchdog_expired_flag;
        logic alarm_match_flag;
        logic supply_low_flag;
        logic timeout_write_enable_n;
        logic [5:0] timeout;
        logic [5:0] count;
        logic trip_d;
        logic sec_d;
        logic irq_on;
        logic [31:0] pulse_cnt;
        logic [7:0] rdata;
    } sslg_st_t;

    sslg_st_t st_r;
    sslg_st_t st_nxt;
    logic [2:0] sync_lv;
    logic trip_s;
    logic lock_s;
    logic bak_s;
    logic wd_tick;
    logic alarm_hit;
    logic wd_expire;
    logic flags_read;
    logic wd_write;
    logic any_src;

    function automatic logic field_ok(input logic [7:0] alarm, input logic [7:0] now);
        // Match bit at MSB; 1 excludes field
        field_ok = alarm[SSLG_MATCH_BIT] || (alarm[6:0] == now[6:0]);
    endfunction

    sslg_sync #(.WIDTH(3)) u_sync (
        .clk_sys(clk_sys),
        .reset(reset),
        .async_in({below_trip_threshold, below_lockout_threshold, below_backup_supply}),
        .sync_out(sync_lv)
    );
    assign trip_s = sync_lv[2];
    assign lock_s = sync_lv[1];
    assign bak_s = sync_lv[0];

    sslg_divider #(.PERIOD(WD_TICK_CYC)) u_div (
        .clk_sys(clk_sys),
        .reset(reset),
        .run(!oscillator_enable_n && !lock_s),
        .tick(wd_tick)
    );

    assign access_enable = !lock_s;
    assign backup_supply_sel = bak_s;

    assign flags_read = access_enable && bus.cs && bus.rd_done && !bus.wr && (bus.addr == SSLG_ADDR_FLAGS);
    assign wd_write = access_enable && bus.cs && bus.wr && (bus.addr == SSLG_ADDR_WDOG);

    // per field compare MSB select all excluded fires each second
    // rate from fields no special cases
    assign alarm_hit = second_tick && !st_r.sec_d
        && field_ok(alarm_regs.seconds, now_time.seconds)
        && field_ok(alarm_regs.minutes, now_time.minutes)
        && field_ok(alarm_regs.hours, now_time.hours)
        && field_ok(alarm_regs.date, now_time.date);

    assign wd_expire = wd_tick && (st_r.timeout != 6'h00) && (st_r.count == 6'h01);

    assign any_src = (st_r.alarm_match_flag && alarm_irq_enable)
        || (st_r.watchdog_expired_flag && wdog_irq_enable)
        || (st_r.supply_low_flag && pfail_irq_enable);

    always_comb begin
        st_nxt = st_r;
        st_nxt.sec_d = second_tick;
        st_nxt.trip_d = trip_s;
        st_nxt.rdata = 8'h00;
        if (bus.cs && !bus.wr && access_enable) begin
            if (bus.addr == SSLG_ADDR_FLAGS) begin
                st_nxt.rdata = {st_r.watchdog_expired_flag, st_r.alarm_match_flag, st_r.supply_low_flag, 5'h00};
            end else if (bus.addr == SSLG_ADDR_WDOG) begin
                st_nxt.rdata = {1'b0, st_r.timeout_write_enable_n, st_r.timeout};
            end
        end
        if (flags_read) begin
            st_nxt.watchdog_expired_flag = 1'b0;
            st_nxt.alarm_match_flag = 1'b0;
            st_nxt.supply_low_flag = 1'b0;
        end
        if (alarm_hit) begin
            st_nxt.alarm_match_flag = 1'b1;
        end
        if (trip_s && !st_r.trip_d) begin
            st_nxt.supply_low_flag = 1'b1;
        end
        if (wd_tick && st_r.timeout != 6'h00) begin
            if (st_r.count == 6'h01) begin
                st_nxt.count = 6'h00;
            end else if (st_r.count != 6'h00) begin
                st_nxt.count = st_r.count - 6'h01;
            end
        end
        if (wd_expire) begin
            st_nxt.watchdog_expired_flag = 1'b1;
        end
        if (wd_write) begin
            st_nxt.timeout_write_enable_n = bus.wdata[SSLG_WD_WEN_N_BIT];
            if (!st_r.timeout_write_enable_n) begin
                st_nxt.timeout = bus.wdata[5:0];
            end
            if (bus.wdata[SSLG_WD_STROBE_BIT]) begin
                st_nxt.count = st_nxt.timeout;
            end
        end
        if (flags_read) begin
            st_nxt.irq_on = 1'b0;
            st_nxt.pulse_cnt = 32'h0;
        end else if (irq_pulse_mode) begin
            if (st_r.irq_on) begin
                if (st_r.pulse_cnt >= 32'(PULSE_CYC - 1)) begin
                    st_nxt.irq_on = 1'b0;
                end else begin
                    st_nxt.pulse_cnt = st_r.pulse_cnt + 32'h1;
                end
            end else if (any_src && st_r.pulse_cnt == 32'h0) begin
                st_nxt.irq_on = 1'b1;
            end
        end else begin
            st_nxt.irq_on = any_src;
            st_nxt.pulse_cnt = 32'h0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_r <= '0;
            st_r.timeout <= TIMEOUT_INIT;
            st_r.count <= TIMEOUT_INIT;
            st_r.timeout_write_enable_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign timeout_value = st_r.timeout;
    assign wd_count = st_r.count;
    // pin follows qualified interrupt state
    // Active high push-pull only above lockout; active low open drain
    assign int_out = irq_active_high && st_r.irq_on;
    assign int_oe = irq_active_high ? (!lock_s) : st_r.irq_on;
endmodule
`default_nettype wire

// >>> sslg_supervisor_test.sv
/*
 Bench for the supervisor logic.
 Short tick and pulse counts; one 20 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module sslg_supervisor_test
    import sslg_pkg::*;
;
    logic clk_sys = 1'b0, reset = 1'b1, rvld, access_enable, backup_sel, int_out, int_oe;
    logic second_tick = 1'b0, oscillator_enable_n = 1'b0, alarm_irq_enable = 1'b0, pfail_irq_enable = 1'b0;
    logic wdog_irq_enable = 1'b0, irq_active_high = 1'b0;
    logic irq_pulse_mode = 1'b0, below_trip = 1'b0, below_lock = 1'b0, below_bak = 1'b0;
    sslg_bus_t bus;
    sslg_time_t now_time = '0, alarm_regs = '0;
    logic [7:0] rdata;
    logic [5:0] timeout_value, wd_count, t;
    logic [3:0] m;
    logic [3:0] pats [6] = '{4'hF, 4'hE, 4'hC, 4'h8, 4'h0, 4'h5};
    logic [7:0] exp_q[$], msk_q[$];
    int failures = 0, num_checks = 0, cycles = 0;
    sslg_supervisor #(.WD_TICK_CYC(10), .PULSE_CYC(20), .TIMEOUT_INIT(6'h03)) i_sslg_supervisor (
        .clk_sys(clk_sys), .reset(reset), .bus(bus), .rdata(rdata), .now_time(now_time), .alarm_regs(alarm_regs),
        .second_tick(second_tick), .oscillator_enable_n(oscillator_enable_n), .alarm_irq_enable(alarm_irq_enable),
        .wdog_irq_enable(wdog_irq_enable), .pfail_irq_enable(pfail_irq_enable), .irq_active_high(irq_active_high),
        .irq_pulse_mode(irq_pulse_mode), .below_trip_threshold(below_trip), .below_lockout_threshold(below_lock),
        .below_backup_supply(below_bak), .access_enable(access_enable), .backup_supply_sel(backup_sel),
        .timeout_value(timeout_value), .wd_count(wd_count), .int_out(int_out), .int_oe(int_oe));
    sslg_host i_sslg_host (.clk_sys(clk_sys), .bus(bus), .rvld(rvld));
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic rd(input logic [14:0] a, input logic [7:0] e, input logic [7:0] mk);
        exp_q.push_back(e);
        msk_q.push_back(mk);
        i_sslg_host.xfer(1'b0, a, 8'h00, 1'b1);
    endtask
    task automatic wr(input logic [7:0] v);
        i_sslg_host.xfer(1'b1, SSLG_ADDR_WDOG, v, 1'b0);
    endtask
    task automatic tick();
        second_tick = 1'b1;
        cyc(3);
        second_tick = 1'b0;
        cyc(6);
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        if (rvld && exp_q.size() > 0) begin
            `CHK(rdata & msk_q[0], exp_q[0])
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            $display("[FAIL] %0t timeout", $time);
            summarize();
        end
    end
    initial begin
        void'($urandom(32'hA6E79292));
        cyc(20);
        reset = 1'b0;
        cyc(60);
        rd(SSLG_ADDR_FLAGS, 8'h80, 8'hE0);
        rd(SSLG_ADDR_FLAGS, 8'h00, 8'hE0);
        $display("test powerup done");
        t = 6'(8 + $urandom % 56);
        wr({2'b00, ~t});
        rd(SSLG_ADDR_WDOG, 8'h03, 8'h7F);
        wr({2'b01, t});
        rd(SSLG_ADDR_WDOG, {2'b01, t}, 8'h7F);
        repeat (8) wr(8'hC0);
        rd(SSLG_ADDR_FLAGS, 8'h00, 8'hE0);
        oscillator_enable_n = 1'b1;
        wdog_irq_enable = 1'b1;
        wr(8'hC0);
        cyc(10 * t + 40);
        `CHK(int_oe, 1'b0)
        rd(SSLG_ADDR_FLAGS, 8'h00, 8'hE0);
        oscillator_enable_n = 1'b0;
        cyc(10 * t + 40);
        `CHK(int_oe, 1'b1)
        rd(SSLG_ADDR_FLAGS, 8'h80, 8'hE0);
        wr(8'h00);
        wr(8'h40);
        wr(8'hC0);
        cyc(100);
        rd(SSLG_ADDR_FLAGS, 8'h00, 8'hE0);
        $display("test watchdog done");
        pfail_irq_enable = 1'b1;
        below_trip = 1'b1;
        cyc(6);
        below_trip = 1'b0;
        cyc(6);
        `CHK(int_oe, 1'b1)
        i_sslg_host.xfer(1'b1, SSLG_ADDR_FLAGS, 8'h00, 1'b0);
        rd(SSLG_ADDR_FLAGS, 8'h20, 8'hE0);
        cyc(3);
        `CHK(int_oe, 1'b0)
        irq_pulse_mode = 1'b1;
        below_trip = 1'b1;
        cyc(30);
        `CHK(int_oe, 1'b0)
        below_lock = 1'b1;
        cyc(5);
        `CHK(access_enable, 1'b0)
        wr(8'h00);
        below_lock = 1'b0;
        below_trip = 1'b0;
        cyc(5);
        `CHK(access_enable, 1'b1)
        rd(SSLG_ADDR_WDOG, 8'h40, 8'h7F);
        rd(SSLG_ADDR_FLAGS, 8'h20, 8'hE0);
        pfail_irq_enable = 1'b0;
        irq_pulse_mode = 1'b0;
        below_bak = 1'b1;
        cyc(5);
        `CHK(backup_sel, 1'b1)
        below_bak = 1'b0;
        cyc(5);
        `CHK(backup_sel, 1'b0)
        irq_active_high = 1'b1;
        cyc(2);
        `CHK(int_out, 1'b0)
        pfail_irq_enable = 1'b1;
        below_trip = 1'b1;
        cyc(6);
        `CHK({int_out, int_oe}, 2'b11)
        rd(SSLG_ADDR_FLAGS, 8'h20, 8'hE0);
        cyc(3);
        `CHK(int_out, 1'b0)
        below_trip = 1'b0;
        pfail_irq_enable = 1'b0;
        irq_active_high = 1'b0;
        $display("test power done");
        alarm_irq_enable = 1'b1;
        foreach (pats[i]) begin
            m = pats[i];
            alarm_regs = ($urandom & 32'h7F7F7F7F) | {m[0], 7'h0, m[1], 7'h0, m[2], 7'h0, m[3], 7'h0};
            now_time = (alarm_regs & 32'h7F7F7F7F) ^ {7'h0, m[0], 7'h0, m[1], 7'h0, m[2], 7'h0, m[3]};
            tick();
            rd(SSLG_ADDR_FLAGS, 8'h40, 8'hE0);
            if (m != 4'hF) begin
                now_time = now_time ^ 32'h01010101;
                tick();
                rd(SSLG_ADDR_FLAGS, 8'h00, 8'hE0);
            end
        end
        $display("test alarm done");
        summarize();
    end
endmodule
bind sslg_supervisor sslg_props #(.PULSE_CYC(PULSE_CYC)) i_sslg_props (.clk_sys(clk_sys), .reset(reset),
    .bus(bus), .alarm_regs(alarm_regs), .second_tick(second_tick), .oscillator_enable_n(oscillator_enable_n),
    .alarm_irq_enable(alarm_irq_enable), .irq_active_high(irq_active_high), .irq_pulse_mode(irq_pulse_mode),
    .below_lockout_threshold(below_lockout_threshold), .below_backup_supply(below_backup_supply),
    .access_enable(access_enable), .backup_supply_sel(backup_supply_sel), .timeout_value(timeout_value),
    .wd_count(wd_count), .int_oe(int_oe));
`default_nettype wire

// >>> sslg_sync.sv
/*
 Two-flop synchroniser for a vector of asynchronous levels.
 Assumes inputs are slow comparator or pin levels.
*/
`timescale 1ns/1ns
`default_nettype none
module sslg_sync
    import sslg_pkg::*;
#(
    parameter int WIDTH = 3
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sslg_sync_st_t;
    sslg_sync_st_t st_r;
    sslg_sync_st_t st_nxt;

    always_comb begin
        st_nxt.meta = async_in;
        st_nxt.sync = st_r.meta;
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.sync;
endmodule
`default_nettype wire
